// >>> rtl/lsc_pkg.sv
// Constants, field layout and lookup functions for the segment LCD controller.
// Assumes a single 100 MHz clock and a 32-bit AXI4-Lite register bus.
package lsc_pkg;
  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int NUM_COM   = 4;
  localparam int COM_BYTES = 6;
  localparam int RAM_BYTES = 24;
  localparam int NUM_SEG   = 45;
  localparam int FIRST_SEG = 4;
  localparam int ADDR_W    = 12;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [9:0] IDX_STAT      = 10'h0DB;
  localparam logic [9:0] IDX_MODE      = 10'h0DC;
  localparam logic [9:0] IDX_RAM_FIRST = 10'h0E0;
  localparam logic [9:0] IDX_RAM_LAST  = 10'h0F7;

  // ----------------------------------------------------------------------
  // Mode register fields and codes
  // ----------------------------------------------------------------------
  localparam int         MUX_LSB    = 6;
  localparam int         SRC_LSB    = 3;
  localparam int         RATE_LSB   = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [2:0] SRC_OFF    = 3'h0;
  localparam logic [2:0] SRC_AUX    = 3'h1;
  localparam logic [2:0] RATE_RSV   = 3'h7;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------------
  localparam logic [8:0] SRC_DIV_3  = 9'h020;
  localparam logic [8:0] SRC_DIV_4  = 9'h040;
  localparam logic [8:0] SRC_DIV_5  = 9'h080;
  localparam logic [8:0] SRC_DIV_6  = 9'h100;
  localparam logic [9:0] RATE_DIV_0 = 10'h200;
  localparam logic [9:0] RATE_DIV_1 = 10'h182;
  localparam logic [9:0] RATE_DIV_2 = 10'h100;
  localparam logic [9:0] RATE_DIV_3 = 10'h0C0;
  localparam logic [9:0] RATE_DIV_4 = 10'h080;
  localparam logic [9:0] RATE_DIV_5 = 10'h060;
  localparam logic [9:0] RATE_DIV_6 = 10'h040;

  function automatic logic src_is_int(input logic [2:0] c);
    return c inside {3'h3, 3'h4, 3'h5, 3'h6};
  endfunction

  function automatic logic [8:0] src_div(input logic [2:0] c);
    case (c)
      3'h3:    return SRC_DIV_3;
      3'h4:    return SRC_DIV_4;
      3'h5:    return SRC_DIV_5;
      default: return SRC_DIV_6;
    endcase
  endfunction

  function automatic logic [9:0] rate_div(input logic [2:0] c);
    case (c)
      3'h0:    return RATE_DIV_0;
      3'h1:    return RATE_DIV_1;
      3'h2:    return RATE_DIV_2;
      3'h3:    return RATE_DIV_3;
      3'h4:    return RATE_DIV_4;
      3'h5:    return RATE_DIV_5;
      default: return RATE_DIV_6;
    endcase
  endfunction

  function automatic logic [2:0] mux_count(input logic [1:0] c);
    case (c)
      2'h1:    return 3'h1;
      2'h2:    return 3'h2;
      2'h3:    return 3'h3;
      default: return 3'h4;
    endcase
  endfunction
endpackage

// >>> rtl/lsc_tick_if.sv
// Timing strobes shared between divider, scanner and top of the LCD controller.
// Assumes all users sit on the same clock.
`timescale 1ns/1ps
interface lsc_tick_if;
  logic       base_tick;
  logic       frame_end;
  logic [1:0] com_idx;
  modport div  (output base_tick);
  modport scan (input base_tick, output frame_end, output com_idx);
  modport top  (input base_tick, input frame_end, input com_idx);
endinterface

// >>> rtl/lsc_clk_div.sv
// Reference and base-period divider of the LCD controller.
// Assumes aux_tick is a one-cycle pulse synchronous to clock.
`timescale 1ns/1ps
module lsc_clk_div
  import lsc_pkg::*;
(
  // Clock and reset
  input  logic        clock,
  input  logic        sys_rst,
  // Selection
  input  logic [2:0]  src,
  input  logic [2:0]  rate,
  input  logic        aux_tick,
  // Strobes
  lsc_tick_if.div     tk
);
  logic [7:0] pre_q;
  logic [9:0] base_q;
  logic [2:0] rate_q;
  logic       ref_tick;
  logic [8:0] sdiv;
  logic [9:0] rdiv;

  assign sdiv = src_div(src);
  assign rdiv = rate_div(rate);

  // ----------------------------------------------------------------------
  // Reference tick
  // ----------------------------------------------------------------------
  always_comb begin
    ref_tick = 1'b0;
    if (src == SRC_AUX) begin
      ref_tick = aux_tick;
    end else if (src_is_int(src)) begin
      ref_tick = (pre_q == 8'(sdiv - 9'h001)); // RQ14
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || ref_tick || !src_is_int(src)) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 8'h01; // RQ14
    end
  end

  // ----------------------------------------------------------------------
  // Base period
  // ----------------------------------------------------------------------
  // A rate change restarts the base count, so the period in progress is dropped and a whole new one begins
  always_ff @(posedge clock) begin
    rate_q <= rate;
  end

  always_ff @(posedge clock) begin
    if (sys_rst || rate == RATE_RSV || rate != rate_q) begin
      base_q <= 10'h000;
    end else if (ref_tick) begin
      base_q <= (base_q >= rdiv - 10'h001) ? 10'h000 : base_q + 10'h001; // RQ13
    end
  end

  assign tk.base_tick = ref_tick && rate != RATE_RSV && rate == rate_q && base_q >= rdiv - 10'h001; // RQ13

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_off_no_ref:   assert property (src == SRC_OFF |-> !ref_tick) // RQ10
    else $error("reference tick with clock disabled");
  a_base_spacing: assert property (tk.base_tick && rate == 3'h6 && $stable(rate) |-> base_q == 10'h03F) // RQ13
    else $error("base tick not at end of rate count");
endmodule

// >>> rtl/lsc_scan.sv
// Common plate scanner: one common per base period, frame end after the last.
// Assumes base_tick is a one-cycle pulse.
`timescale 1ns/1ps
module lsc_scan
  import lsc_pkg::*;
(
  // Clock and reset
  input  logic        clock,
  input  logic        sys_rst,
  // Control
  input  logic [1:0]  mux,
  input  logic        run,
  // Strobes
  lsc_tick_if.scan    tk
);
  logic [1:0] idx_q;
  logic [2:0] cnt;
  logic       in_rng;

  assign cnt        = mux_count(mux);
  // A ratio cut below the current common restarts the frame on common 0
  assign in_rng     = {1'b0, idx_q} < cnt; // RQ15
  assign tk.com_idx = in_rng ? idx_q : 2'h0; // RQ15
  assign tk.frame_end = tk.base_tick && {1'b0, tk.com_idx} >= cnt - 3'h1; // RQ16

  always_ff @(posedge clock) begin
    if (sys_rst || !run || !in_rng) begin
      idx_q <= 2'h0;
    end else if (tk.base_tick) begin
      idx_q <= tk.frame_end ? 2'h0 : idx_q + 2'h1; // RQ18
    end
  end
endmodule

// >>> rtl/lsc_lcd_ctrl.sv
// Segment LCD controller top: AXI4-Lite registers, display RAM, drive outputs.
// Assumes stop_mode, osc_fail and aux_osc_tick are synchronous to clock.
`timescale 1ns/1ps
// Contract
// RQ1: A set RAM bit turns its segment/common element on, clear keeps it off.
// RQ2: Reset leaves display RAM untouched.
// RQ3: RAM of unused commons stays ordinary read/write storage.
// RQ4: Six bytes per common: E0, E6, EC, F2, ending F7.
// RQ5: Ascending LSB-first map; first byte bits 3..7 drive segments 4..8.
// RQ6: STOP on main clock grounds every segment and common output.
// RQ7: With auxiliary oscillator selected the display runs through STOP.
// RQ8: Clock source change takes effect only at frame end; while the active source is not running the code switches at once.
// RQ9: Software lets the frame finish before STOP, else display goes off.
// RQ10: Source 000 off, 001 auxiliary, 010/111 reserved, others internal.
// RQ11: Mode byte at DC: mux bits 7-6, source 5-3, rate 2-0.
// RQ12: Mux field sets how many commons are driven per frame.
// RQ13: Rate divides reference by 512,386,256,192,128,96,64; 111 reserved.
// RQ14: Source codes 3..6 divide internal clock by 32,64,128,256.
// RQ15: Mux 00 four commons, 01 one, 10 two, 11 three.
// RQ16: Frame rate equals base rate over active common count.
// RQ17: Clock failure grounds all segment and common outputs.
// RQ18: One common per base period; segments show that common's bits.
module lsc_lcd_ctrl
  import lsc_pkg::*;
(
  // Clock and reset
  input  logic                        clock,
  input  logic                        sys_rst,
  // AXI4-Lite write
  input  logic [lsc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  logic                        s_axi_awvalid,
  output logic                        s_axi_awready,
  input  logic [31:0]                 s_axi_wdata,
  input  logic [3:0]                  s_axi_wstrb,
  input  logic                        s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  logic                        s_axi_bready,
  // AXI4-Lite read
  input  logic [lsc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  logic                        s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  logic                        s_axi_rready,
  // System state
  input  logic                        stop_mode,
  input  logic                        osc_fail,
  input  logic                        aux_osc_tick,
  // Panel drive
  output logic                        lcd_drive_en,
  output logic [lsc_pkg::NUM_COM-1:0] backplane_on,
  output logic [lsc_pkg::NUM_SEG-1:0] segment_on
);
  logic [7:0]  mode_q;
  logic [2:0]  src_act_q;
  logic [7:0]  ram_q [RAM_BYTES];
  logic [9:0]  aw_q;
  logic        aw_have_q;
  logic [7:0]  w_data_q;
  logic        w_strb_q;
  logic        w_have_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic        drive_q;
  logic [3:0]  com_q;
  logic [44:0] seg_q;
  logic        wr_go;
  logic        wr_ram;
  logic        wr_mode;
  logic [4:0]  wri;
  logic [9:0]  rw;
  logic        src_run;
  logic        clk_live;
  logic        drive_d;
  logic [47:0] row;
  logic [44:0] seg_sel;
  logic [5:0]  stat;

  lsc_tick_if tk ();

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  // Address and data are latched independently so either may arrive first
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  assign wr_go   = aw_have_q && w_have_q;
  assign wr_mode = wr_go && w_strb_q && aw_q == IDX_MODE; // RQ11
  assign wr_ram  = wr_go && w_strb_q && aw_q >= IDX_RAM_FIRST && aw_q <= IDX_RAM_LAST;
  assign wri     = 5'(aw_q - IDX_RAM_FIRST);
  assign rw      = s_axi_araddr[ADDR_W-1:2];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      aw_have_q <= 1'b0;
      aw_q      <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_q      <= s_axi_awaddr[ADDR_W-1:2];
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      w_have_q <= 1'b0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata[7:0];
      w_strb_q <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (aw_q == IDX_MODE || aw_q == IDX_STAT ||
                   (aw_q >= IDX_RAM_FIRST && aw_q <= IDX_RAM_LAST)) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign stat = {drive_q, src_act_q, tk.com_idx};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
      if (rw == IDX_MODE) begin
        rdata_q <= {24'h000000, mode_q}; // RQ11
      end else if (rw == IDX_STAT) begin
        rdata_q <= {26'h0000000, stat};
      end else if (rw >= IDX_RAM_FIRST && rw <= IDX_RAM_LAST) begin
        rdata_q <= {24'h000000, ram_q[5'(rw - IDX_RAM_FIRST)]}; // RQ3
      end else begin
        rresp_q <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Mode register and display RAM
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_q <= MODE_RESET;
    end else if (wr_mode) begin
      mode_q <= w_data_q; // RQ11
    end
  end

  // No reset: contents stay as they were, any byte is free storage
  always_ff @(posedge clock) begin
    if (wr_ram) begin
      ram_q[wri] <= w_data_q; // RQ2 RQ3
    end
  end

  // ----------------------------------------------------------------------
  // Clock source and run state
  // ----------------------------------------------------------------------
  assign src_run = src_act_q == SRC_AUX || src_is_int(src_act_q); // RQ10
  // Main clock is gone in STOP, so an internal source stops ticking, the scan returns to common 0 and the source never switches
  assign clk_live = src_run && !osc_fail && !(stop_mode && src_act_q != SRC_AUX); // RQ6 RQ7 RQ9 RQ17
  assign drive_d  = clk_live && mode_q[RATE_LSB+:3] != RATE_RSV; // RQ13

  // With no running source there is no frame to wait for
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      src_act_q <= SRC_OFF;
    end else if (tk.frame_end || !src_run) begin
      src_act_q <= mode_q[SRC_LSB+:3]; // RQ8
    end
  end

  lsc_clk_div u_div (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .src      (clk_live ? src_act_q : SRC_OFF),
    .rate     (mode_q[RATE_LSB+:3]),
    .aux_tick (aux_osc_tick),
    .tk       (tk.div)
  );

  lsc_scan u_scan (
    .clock   (clock),
    .sys_rst (sys_rst),
    .mux     (mode_q[MUX_LSB+:2]),
    .run     (drive_d),
    .tk      (tk.scan)
  );

  // ----------------------------------------------------------------------
  // Segment selection and output drive
  // ----------------------------------------------------------------------
  always_comb begin
    row = 48'h0;
    for (int b = 0; b < COM_BYTES; b++) begin
      row[b*8+:8] = ram_q[5'(tk.com_idx * 3'(COM_BYTES) + 3'(b))]; // RQ4 RQ5
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SEG; g++) begin : g_seg
      assign seg_sel[g] = row[g+FIRST_SEG-1]; // RQ5
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (sys_rst || !drive_d) begin
      drive_q <= 1'b0;
      com_q   <= 4'h0;
      seg_q   <= '0;
    end else begin
      drive_q <= 1'b1;
      com_q   <= 4'(4'h1 << tk.com_idx); // RQ12 RQ15 RQ18
      seg_q   <= seg_sel; // RQ1
    end
  end

  assign lcd_drive_en = drive_q;
  assign backplane_on = com_q;
  assign segment_on   = seg_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_stop_grounds: assert property (stop_mode && src_act_q != SRC_AUX |=> !drive_q && com_q == 4'h0 && seg_q == '0) // RQ6
    else $error("outputs not grounded in stop on main clock");
  a_fail_grounds: assert property (osc_fail |=> !drive_q && com_q == 4'h0 && seg_q == '0) // RQ17
    else $error("outputs not grounded on clock failure");
  a_aux_in_stop: assert property (stop_mode && src_act_q == SRC_AUX && !osc_fail && mode_q[2:0] != RATE_RSV |=> drive_q) // RQ7
    else $error("display stopped on auxiliary source");
  a_src_frame_end: assert property (src_act_q != $past(src_act_q) |-> $past(tk.frame_end) || !$past(src_run)) // RQ8
    else $error("source changed mid-frame");
  a_src_off_dark: assert property (src_act_q == SRC_OFF |=> !drive_q) // RQ10
    else $error("display on with clock disabled");
  a_mode_write: assert property (wr_mode |=> mode_q == $past(w_data_q)) // RQ11
    else $error("mode register not updated");
  a_ram_store: assert property (wr_ram |=> ram_q[$past(wri)] == $past(w_data_q)) // RQ3
    else $error("display RAM write lost");
  a_first_byte: assert property (drive_q && com_q == 4'h1 && $past(drive_q) |-> seg_q[4:0] == $past(ram_q[0][7:3])) // RQ5
    else $error("first common byte mapped wrongly");
  a_com_range: assert property (drive_q |-> $onehot(com_q) && // RQ15
                                {1'b0, com_q} < (5'h01 << $past(mux_count(mode_q[7:6]))))
    else $error("inactive common driven");
  a_frame_len: assert property (tk.frame_end |-> tk.base_tick && 3'(tk.com_idx) == mux_count(mode_q[7:6]) - 3'h1) // RQ16
    else $error("frame ended at wrong common");

  c_aux_stop:   cover property (stop_mode && drive_q);
  c_src_switch: cover property (tk.frame_end && src_act_q != mode_q[5:3]);
  c_quad_frame: cover property (tk.frame_end && tk.com_idx == 2'h3);
endmodule

// >>> verification/lsc_panel_model.sv
// Passive glass model: records the pattern shown on each backplane.
// Assumes panel drive outputs change only after rising clock edges.
`timescale 1ns/1ps
module lsc_panel_model (
  // Clock and clear
  input  logic        clock,
  input  logic        clr,
  // Panel drive
  input  logic        drv_en,
  input  logic [3:0]  bp,
  input  logic [44:0] seg,
  // Observations
  output logic [3:0]  seen_mask,
  output logic [44:0] seen [4],
  output logic        bias_err
);
  // ---------------------------------------------------------------
  // Capture
  // ---------------------------------------------------------------
  // Lit lines with drive off, or two plates at once, would bias the glass
  always_ff @(posedge clock) begin
    if (clr) begin
      seen_mask <= 4'h0;
      bias_err  <= 1'h0;
    end else begin
      if ((!drv_en && (bp != 4'h0 || seg != 45'h0)) || $countones(bp) > 1)
        bias_err <= 1'h1;
      for (int k = 0; k < 4; k++) begin
        if (bp[k]) begin
          seen_mask[k] <= 1'h1;
          seen[k]      <= seg;
        end
      end
    end
  end
endmodule

// >>> verification/lsc_lcd_ctrl_tb.sv
// Self-checking bench for the segment LCD controller over AXI4-Lite.
// Assumes the passive panel model and a 100 MHz clock.
`timescale 1ns/1ps
module lsc_lcd_ctrl_tb;
  import lsc_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam logic [11:0] MA = {IDX_MODE, 2'h0};
  localparam logic [11:0] SA = {IDX_STAT, 2'h0};
  logic        clock = 1'h0, sys_rst = 1'h1, stop_mode = 1'h0, osc_fail = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, aux_osc_tick = 1'h0;
  logic        aux_run = 1'h0, m_clr = 1'h1, bias_err;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, backplane_on, seen_mask;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        lcd_drive_en;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [44:0] segment_on;
  logic [44:0] seen [4];
  logic [7:0]  ram [24];
  logic [7:0]  rd;
  logic [7:0]  offm [4] = '{8'h5F, 8'h46, 8'h56, 8'h7E};
  int          error_cnt = 0, check_count = 0, cyc = 0, n, m;

  lsc_lcd_ctrl lsc_lcd_ctrl_i (.*);
  lsc_panel_model lsc_panel_model_i (.clock(clock), .clr(m_clr), .drv_en(lcd_drive_en),
    .bp(backplane_on), .seg(segment_on), .seen_mask(seen_mask), .seen(seen), .bias_err(bias_err));

  always #5 clock = ~clock;
  // Auxiliary oscillator sped up to one pulse every two clocks
  always @(posedge clock) aux_osc_tick <= aux_run & ~aux_osc_tick;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_p, w_p, ah, wh, bh;
    aw_p = 1'h1;
    w_p = 1'h1;
    bh = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!bh) begin
      #1;
      ah = aw_p && s_axi_awready;
      wh = w_p && s_axi_wready;
      bh = s_axi_bvalid;
      if (bh) chk(s_axi_bresp, er);
      @(posedge clock);
      if (ah) s_axi_awvalid <= 1'h0;
      if (wh) s_axi_wvalid <= 1'h0;
      aw_p = aw_p && !ah;
      w_p = w_p && !wh;
    end
    chk({aw_p, w_p}, 2'h0);
    s_axi_bready <= 1'h0;
    @(posedge clock);
  endtask

  task automatic rdr(input logic [11:0] a, output logic [7:0] d, input logic [1:0] er);
    logic ah, rh;
    rh = 1'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!rh) begin
      #1;
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata[7:0];
      if (rh) chk(s_axi_rresp, er);
      @(posedge clock);
      if (ah) s_axi_arvalid <= 1'h0;
    end
    chk(s_axi_arvalid, 1'h0);
    s_axi_rready <= 1'h0;
    @(posedge clock);
  endtask

  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    rdr(a, rd, RESP_OKAY);
    chk(rd, e);
  endtask

  // Cycles up to the next rise of the first backplane
  task automatic wrise(output int c, input int lim);
    logic p;
    p = 1'h1;
    c = 0;
    while (!(backplane_on[0] && !p) && c < lim) begin
      p = backplane_on[0];
      @(posedge clock);
      #1;
      c++;
    end
  endtask

  task automatic wen(input logic v);
    for (int i = 0; i < 9000 && lcd_drive_en !== v; i++) begin
      @(posedge clock);
      #1;
    end
    repeat (2) @(posedge clock);
    #1;
  endtask

  function automatic logic [11:0] ra(input int i);
    return {IDX_RAM_FIRST + 10'(i), 2'h0};
  endfunction

  function automatic logic [44:0] exp_seg(input int k);
    for (int s = 4; s <= 48; s++) exp_seg[s-4] = ram[6*k + (s-1)/8][(s-1)%8];
  endfunction

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'h0;
    m_clr <= 1'h0;
    @(posedge clock);
    rc(MA, MODE_RESET);
    chk({lcd_drive_en, backplane_on, segment_on}, 50'h0);
    $display("test reset done");
    wr(MA, 8'h40, RESP_OKAY);
    for (int i = 0; i < 24; i++) begin
      ram[i] = 8'h5A ^ 8'(i * 37);
      wr(ra(i), ram[i], RESP_OKAY);
    end
    for (int i = 0; i < 24; i++) rc(ra(i), ram[i]);
    rc(MA, 8'h40);
    rdr(12'hFFC, rd, RESP_SLVERR);
    chk(rd, 8'h0);
    wr(12'h004, 8'hFF, RESP_SLVERR);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'h0;
    @(posedge clock);
    rc(ra(0), ram[0]);
    rc(ra(23), ram[23]);
    rc(MA, MODE_RESET);
    $display("test registers done");
    // A single common never falls, so its frame shows only as a steady plate
    for (int j = 1; j < 5; j++) begin
      m = j % 4;
      wr(MA, {2'(m), 3'h3, 3'h6}, RESP_OKAY);
      if (m != 1) wrise(n, 9000);
      m_clr <= 1'h1;
      @(posedge clock);
      #1;
      m_clr <= 1'h0;
      wrise(n, 9000);
      chk(n, m == 1 ? 9000 : (m == 0 ? 4 : m) * 32 * 64 - 1);
      chk(seen_mask, 4'hF >> (m == 0 ? 0 : 4 - m));
      for (int k = 0; k < 4; k++) if (seen_mask[k]) chk(seen[k], exp_seg(k));
    end
    $display("test scan done");
    aux_run <= 1'h1;
    wr(MA, 8'h4C, RESP_OKAY);
    rdr(SA, rd, RESP_OKAY);
    chk(rd[4:2], 3'h3);
    repeat (4200) @(posedge clock);
    rdr(SA, rd, RESP_OKAY);
    chk(rd[4:2], 3'h1);
    wr(MA, 8'h8C, RESP_OKAY);
    stop_mode <= 1'h1;
    wrise(n, 9000);
    wrise(n, 9000);
    chk(n, 2 * 128 * 2);
    chk(lcd_drive_en, 1'h1);
    stop_mode <= 1'h0;
    $display("test standby done");
    wr(MA, 8'h9E, RESP_OKAY);
    repeat (300) @(posedge clock);
    wrise(n, 9000);
    wrise(n, 9000);
    chk(n, 2 * 32 * 64);
    stop_mode <= 1'h1;
    wen(1'h0);
    chk({lcd_drive_en, backplane_on, segment_on}, 50'h0);
    stop_mode <= 1'h0;
    wen(1'h1);
    osc_fail <= 1'h1;
    wen(1'h0);
    chk({lcd_drive_en, backplane_on, segment_on}, 50'h0);
    osc_fail <= 1'h0;
    foreach (offm[i]) begin
      wr(MA, 8'h5E, RESP_OKAY);
      wen(1'h1);
      chk(lcd_drive_en, 1'h1);
      wr(MA, offm[i], RESP_OKAY);
      wen(1'h0);
      chk({lcd_drive_en, backplane_on, segment_on}, 50'h0);
    end
    chk(bias_err, 1'h0);
    $display("test shutdown done");
    give_verdict();
  end
endmodule
